//--- include/ifc_defines.svh
// register offsets, field positions, command codes and fill levels of the flow block
`ifndef IFC_DEFINES_SVH
`define IFC_DEFINES_SVH
`define IFC_REG_MODE      3'h0
`define IFC_REG_CMD       3'h1
`define IFC_REG_RESUME    3'h2
`define IFC_REG_PAUSE     3'h3
`define IFC_REG_MASK      3'h4
`define IFC_REG_ISR       3'h5
`define IFC_REG_XSTAT     3'h6
`define IFC_REG_BID       3'h7
`define IFC_BIT_TRANSP    7
`define IFC_BIT_AUTO_RX   3
`define IFC_BIT_AUTO_TX   2
`define IFC_BIT_FLOW_IRQ  4
`define IFC_CMD_TX_EN     5'h01
`define IFC_CMD_TX_DIS    5'h02
`define IFC_CMD_SEND_ON   5'h12
`define IFC_CMD_SEND_OFF  5'h13
`define IFC_CMD_KILL      5'h14
`define IFC_CMD_PAUSE     5'h15
`define IFC_CMD_RESUME    5'h16
`define IFC_CMD_RESET     5'h1F
`define IFC_XOFF_LEVEL    12
`define IFC_XON_LEVEL     8
`define IFC_BREAK_CHAR    8'h00
`endif

//--- include/ifc_pkg.sv
// types of the in-band flow-control block
package ifc_pkg;
    typedef struct packed {
        logic        transp;
        logic        mode_rx;
        logic        mode_tx;
        logic [7:0]  on_char;
        logic [7:0]  off_char;
        logic [7:0]  bid;
        logic        mask4;
        logic        recog_en;
        logic        ev;
        logic        got_on;
        logic        got_off;
        logic        irq;
        logic        xoff_out;
        logic        last_off;
        logic        auto_pause;
        logic        host_pause;
        logic        pend_on;
        logic        pend_off;
        logic        req_v;
        logic        req_off;
        logic [7:0]  req_char;
        logic        dp_wr;
        logic [2:0]  dp_idx;
        logic        rdy;
        logic [31:0] hrdata;
        logic        push;
        logic [7:0]  push_data;
        logic [2:0]  push_err;
        logic        tx_en;
        logic        flush;
        logic        cmd_v;
        logic [4:0]  cmd;
    } ifc_state_t;
endpackage : ifc_pkg

//--- rtl/ifc_flow_ctrl.sv
// in-band xon/xoff flow control of one channel, with its ahb-lite register slave
`timescale 1ns/100ps
`include "ifc_defines.svh"

// Functional notes
// [RULE1] auto-transmitter: recognized pause char stops transmitter after current character
// [RULE2] resume char or reset restarts; reset flushes unsent transmit queue
// [RULE3] transmitter commands ignored while auto-transmitter mode is on
// [RULE4] paused transmitter still takes queue writes, reports fill, keeps status
// [RULE5] received break counts as a zero character for detection
// [RULE6] flow char recognized only with queue room; overrun char ignored entirely
// [RULE7] flow chars with errors still valid; error bits stored alongside
// [RULE8] auto-receiver: send pause above 12 filled, resume below 8
// [RULE9] flow char never disturbs loaded character; queued data sent afterwards
// [RULE10] pending flow char dropped if its fill condition vanishes first
// [RULE11] track unrescinded pause; clear when mode bit 3 written zero
// [RULE12] host pause command holds transmitter until reset or resume command
// [RULE13] host pause not lifted by resume char or transmitter re-enable
// [RULE14] repeated send commands harmless; opposite command cancels pending one
// [RULE15] kill cancels pending send commands; no effect in automatic modes
// [RULE16] flow char once loaded is never aborted
// [RULE17] mode bits 3,2 reset zero; bit 2 gating, bit 3 fill-driven sending
// [RULE18] mode bit 7 set keeps recognized flow chars out of queue
// [RULE19] only recognition raises the event; flow transmit activity never does
// [RULE20] comparators work even with both mode bits zero
// [RULE21] event gated by mask bit 4, bid level, status bit 4, details
// [RULE22] reset disables recognition and its event
// [RULE23] nonzero flow mode blocks command-driven flow character sending
// [RULE24] flow chars use channel's programmed character format
module ifc_flow_ctrl
    import ifc_pkg::*;
#(
    parameter int FILL_W = 5
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              ce,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output      logic              hreadyout,
    output      logic              hresp,
    output      logic [31:0]       hrdata,
    input  wire logic              rx_char_valid,
    input  wire logic [7:0]        rx_char,
    input  wire logic [2:0]        rx_err,
    input  wire logic              rx_break,
    input  wire logic              rx_room,
    input  wire logic [FILL_W-1:0] rx_fill,
    output      logic              rx_push,
    output      logic [7:0]        rx_push_data,
    output      logic [2:0]        rx_push_err,
    output      logic              tx_enable,
    output      logic              tx_flow_req,
    output      logic [7:0]        tx_flow_char,
    output      logic              tx_flow_is_pause,
    input  wire logic              tx_flow_ack,
    output      logic              tx_cmd_valid,
    output      logic [4:0]        tx_cmd,
    output      logic              tx_queue_flush,
    output      logic              flow_bid,
    output      logic [7:0]        flow_bid_level
);
    localparam logic [FILL_W-1:0] XOFF_LVL = FILL_W'(`IFC_XOFF_LEVEL);
    localparam logic [FILL_W-1:0] XON_LVL  = FILL_W'(`IFC_XON_LEVEL);

    if (FILL_W < 4) begin : g_chk
        $error("FILL_W too small for the fill levels");
    end

    ifc_state_t st;
    ifc_state_t next_st;

    logic [7:0] rx_c;
    logic       hit_on;
    logic       hit_off;
    logic       take;
    logic       host;
    logic [4:0] wcmd;
    logic       wr_cmd;

    // [RULE5] break as zero
    assign rx_c    = rx_break ? `IFC_BREAK_CHAR : rx_char;
    // [RULE20] comparators on in every mode, gated by recog_en
    assign hit_on  = st.recog_en && rx_c == st.on_char;
    assign hit_off = st.recog_en && rx_c == st.off_char;
    assign take    = hsel && hready && htrans[1];
    assign host    = !st.mode_rx && !st.mode_tx;
    assign wcmd    = hwdata[7:3];
    assign wr_cmd  = st.dp_wr && st.dp_idx == `IFC_REG_CMD;

    always_comb begin
        next_st        = st;
        next_st.push   = 1'b0;
        next_st.flush  = 1'b0;
        next_st.cmd_v  = 1'b0;
        next_st.rdy    = 1'b1;
        // address phase; status read clears before any new event sets
        next_st.dp_wr  = take && hwrite;
        next_st.dp_idx = haddr[4:2];
        if (take && !hwrite) begin
            case (haddr[4:2])
                `IFC_REG_MODE:   next_st.hrdata = {24'h000000, st.transp, 3'h0,
                                                  st.mode_rx, st.mode_tx, 2'h0};
                `IFC_REG_RESUME: next_st.hrdata = {24'h000000, st.on_char};
                `IFC_REG_PAUSE:  next_st.hrdata = {24'h000000, st.off_char};
                `IFC_REG_MASK:   next_st.hrdata = {27'h0000000, st.mask4, 4'h0};
                `IFC_REG_ISR:    next_st.hrdata = {27'h0000000, st.ev, 4'h0};
                `IFC_REG_XSTAT:  next_st.hrdata = {24'h000000, st.host_pause,
                                                  st.auto_pause, st.xoff_out, st.last_off,
                                                  st.ev, st.recog_en, st.got_off, st.got_on};
                `IFC_REG_BID:    next_st.hrdata = {24'h000000, st.bid};
                default:         next_st.hrdata = 32'h00000000;
            endcase
            if (haddr[4:2] == `IFC_REG_XSTAT) begin
                next_st.ev      = 1'b0;
                next_st.got_on  = 1'b0;
                next_st.got_off = 1'b0;
            end
        end
        // [RULE6] no room, nothing happens
        if (rx_char_valid && rx_room) begin
            if (hit_on || hit_off) begin
                // [RULE19] event on recognition only
                next_st.ev      = 1'b1;
                next_st.got_on  = next_st.got_on | hit_on;
                next_st.got_off = next_st.got_off | hit_off;
                // [RULE1] pause char gates transmitter
                if (st.mode_tx && hit_off) begin
                    next_st.auto_pause = 1'b1;
                end
                // [RULE2] resume char restarts
                if (st.mode_tx && hit_on && !hit_off) begin
                    next_st.auto_pause = 1'b0;
                end
            end
            // [RULE18] transparency strips flow chars
            next_st.push      = !((hit_on || hit_off) && st.transp);
            next_st.push_data = rx_c;
            // [RULE7] errors kept with char
            next_st.push_err  = rx_err;
        end
        // data phase write
        if (st.dp_wr) begin
            case (st.dp_idx)
                `IFC_REG_MODE: begin
                    next_st.transp  = hwdata[`IFC_BIT_TRANSP];
                    next_st.mode_rx = hwdata[`IFC_BIT_AUTO_RX];
                    next_st.mode_tx = hwdata[`IFC_BIT_AUTO_TX];
                    // [RULE11] tracking cleared, no resume sent
                    if (!hwdata[`IFC_BIT_AUTO_RX]) begin
                        next_st.xoff_out = 1'b0;
                    end
                    // leaving gating mode must not strand the transmitter
                    if (!hwdata[`IFC_BIT_AUTO_TX]) begin
                        next_st.auto_pause = 1'b0;
                    end
                end
                `IFC_REG_CMD: begin
                    case (wcmd)
                        // [RULE2] reset restarts and flushes
                        `IFC_CMD_RESET: begin
                            next_st.flush      = 1'b1;
                            next_st.auto_pause = 1'b0;
                            next_st.host_pause = 1'b0;
                            next_st.pend_on    = 1'b0;
                            next_st.pend_off   = 1'b0;
                            // [RULE22] recognition off
                            next_st.recog_en   = 1'b0;
                            next_st.ev         = 1'b0;
                        end
                        // [RULE14] later command cancels opposite
                        // [RULE23] only in host mode
                        `IFC_CMD_SEND_ON: begin
                            if (host) begin
                                next_st.pend_on  = 1'b1;
                                next_st.pend_off = 1'b0;
                            end
                        end
                        `IFC_CMD_SEND_OFF: begin
                            if (host) begin
                                next_st.pend_off = 1'b1;
                                next_st.pend_on  = 1'b0;
                            end
                        end
                        // [RULE15] kill in host mode only
                        `IFC_CMD_KILL: begin
                            if (host) begin
                                next_st.pend_on  = 1'b0;
                                next_st.pend_off = 1'b0;
                            end
                        end
                        // [RULE12] host pause and resume
                        `IFC_CMD_PAUSE: begin
                            if (host) begin
                                next_st.host_pause = 1'b1;
                            end
                        end
                        `IFC_CMD_RESUME: begin
                            next_st.host_pause = 1'b0;
                        end
                        // [RULE3] blocked in auto-transmitter mode
                        // [RULE13] enable commands never touch host pause
                        `IFC_CMD_TX_EN, `IFC_CMD_TX_DIS: begin
                            next_st.cmd_v = !st.mode_tx;
                            next_st.cmd   = wcmd;
                        end
                        default: begin
                            next_st.cmd_v = 1'b0;
                        end
                    endcase
                end
                `IFC_REG_RESUME: begin
                    next_st.on_char  = hwdata[7:0];
                    next_st.recog_en = 1'b1;
                end
                `IFC_REG_PAUSE: begin
                    next_st.off_char = hwdata[7:0];
                    next_st.recog_en = 1'b1;
                end
                `IFC_REG_MASK: begin
                    next_st.mask4 = hwdata[`IFC_BIT_FLOW_IRQ];
                end
                `IFC_REG_BID: begin
                    next_st.bid = hwdata[7:0];
                end
                default: begin
                    next_st.dp_wr = next_st.dp_wr;
                end
            endcase
        end
        // [RULE16] a loaded flow char is the transmitter's; only the record changes
        if (tx_flow_ack && st.req_v) begin
            next_st.last_off = st.req_off;
            if (st.mode_rx) begin
                next_st.xoff_out = st.req_off;
            end
            if (st.req_off) begin
                next_st.pend_off = 1'b0;
            end else begin
                next_st.pend_on = 1'b0;
            end
        end
        // [RULE8] fill thresholds
        // [RULE10] request follows the live condition, so it drops
        // [RULE9] the transmitter takes it only at a character boundary
        // [RULE24] char is framed by the transmitter's own format
        if (next_st.mode_rx || next_st.mode_tx) begin
            next_st.req_off = next_st.mode_rx && rx_fill > XOFF_LVL && !next_st.xoff_out;
            next_st.req_v   = next_st.req_off ||
                              (next_st.mode_rx && rx_fill < XON_LVL && next_st.xoff_out);
        end else begin
            next_st.req_off = next_st.pend_off;
            next_st.req_v   = next_st.pend_off || next_st.pend_on;
        end
        next_st.req_char = next_st.req_off ? next_st.off_char : next_st.on_char;
        // [RULE4] only the gate; queue and status are untouched
        next_st.tx_en = !(next_st.auto_pause || next_st.host_pause);
        // [RULE21] masked event bid
        next_st.irq   = next_st.ev && next_st.mask4;
    end

    // [RULE17] everything, mode bits included, resets to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign hreadyout        = st.rdy;
    assign hresp            = 1'b0;
    assign hrdata           = st.hrdata;
    assign rx_push          = st.push;
    assign rx_push_data     = st.push_data;
    assign rx_push_err      = st.push_err;
    assign tx_enable        = st.tx_en;
    assign tx_flow_req      = st.req_v;
    assign tx_flow_char     = st.req_char;
    assign tx_flow_is_pause = st.req_off;
    assign tx_cmd_valid     = st.cmd_v;
    assign tx_cmd           = st.cmd;
    assign tx_queue_flush   = st.flush;
    assign flow_bid         = st.irq;
    assign flow_bid_level   = st.bid;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn || !ce);

    sequence s_hit_off;
        rx_char_valid && rx_room && hit_off;
    endsequence
    sequence s_hit_on;
        rx_char_valid && rx_room && hit_on && !hit_off;
    endsequence

    AST_XOFF_PAUSE: assert property (s_hit_off ##0 (st.mode_tx && !st.dp_wr) // [RULE1]
        |=> !tx_enable)
        else $error("pause char did not stop transmitter");
    AST_XON_GO: assert property (s_hit_on ##0 (st.mode_tx && !st.host_pause && !st.dp_wr) // [RULE2]
        |=> tx_enable)
        else $error("resume char did not restart transmitter");
    AST_TX_CMD_BLOCK: assert property (st.mode_tx |=> !tx_cmd_valid) // [RULE3]
        else $error("transmitter command passed in auto mode");
    AST_OVERRUN: assert property (rx_char_valid && !rx_room |=> !rx_push) // [RULE6]
        else $error("char pushed on overrun");
    AST_TRANSP: assert property ((s_hit_off or s_hit_on) ##0 st.transp |=> !rx_push) // [RULE18]
        else $error("flow char pushed while transparent");
    AST_AUTO_OFF: assert property (st.mode_rx && rx_fill > XOFF_LVL && !st.xoff_out // [RULE8]
        && !st.dp_wr && !tx_flow_ack |=> tx_flow_req && tx_flow_is_pause)
        else $error("pause not requested at high fill");
    AST_DROP: assert property (st.mode_rx && rx_fill >= XON_LVL && rx_fill <= XOFF_LVL // [RULE10]
        && !st.dp_wr |=> !tx_flow_req)
        else $error("flow char requested without condition");
    AST_KILL: assert property (wr_cmd && wcmd == `IFC_CMD_KILL && host // [RULE15]
        |=> !tx_flow_req)
        else $error("kill left a request pending");
    AST_HOST_HOLD: assert property (st.host_pause && !wr_cmd // [RULE13]
        |=> !tx_enable)
        else $error("host pause lifted without resume");
    AST_BID: assert property ((s_hit_off or s_hit_on) ##0 (st.mask4 && !st.dp_wr) // [RULE21]
        |=> flow_bid ##1 (flow_bid || $past(take) || $past(st.dp_wr)))
        else $error("recognition event not bid");
endmodule : ifc_flow_ctrl

//--- tb/ifc_tx_model.sv
// transmitter-side partner model: loads flow characters at character boundaries
`timescale 1ns/100ps
module ifc_tx_model #(
    parameter int CHAR_CYC = 4
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       slow,
    input  wire logic       tx_flow_req,
    input  wire logic [7:0] tx_flow_char,
    input  wire logic       tx_flow_is_pause,
    output      logic       tx_flow_ack,
    output      logic [7:0] n_pause,
    output      logic [7:0] n_resume,
    output      logic [7:0] last_char
);
    logic [7:0] bit_cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_flow_ack <= 1'b0;
            bit_cnt     <= 8'h00;
            n_pause     <= 8'h00;
            n_resume    <= 8'h00;
            last_char   <= 8'h00;
        end else begin
            tx_flow_ack <= 1'b0;
            bit_cnt     <= (bit_cnt == 8'(CHAR_CYC - 1)) ? 8'h00 : bit_cnt + 8'h01;
            // load only at a boundary
            // slow stands for a long data character still shifting out
            if (bit_cnt == 8'h00 && !slow && tx_flow_req) begin
                tx_flow_ack <= 1'b1;
                last_char   <= tx_flow_char;
                if (tx_flow_is_pause) begin
                    n_pause <= n_pause + 8'h01;
                end else begin
                    n_resume <= n_resume + 8'h01;
                end
            end
        end
    end
endmodule : ifc_tx_model

//--- tb/inband_flow_control_tb.sv
// self-checking bench of the in-band flow-control block
`timescale 1ns/100ps
module inband_flow_control_tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic        rx_char_valid = 1'b0, rx_break = 1'b0, rx_room = 1'b1, pv;
    logic [7:0]  rx_char = 8'h00, pd, rx_push_data, tx_flow_char, flow_bid_level;
    logic [7:0]  n_pause, n_resume, last_char;
    logic [2:0]  rx_err = 3'h0, pe, rx_push_err;
    logic [4:0]  rx_fill = 5'h00, tx_cmd;
    logic        hreadyout, hresp, rx_push, tx_enable, tx_flow_req, tx_flow_is_pause;
    logic        tx_flow_ack, tx_cmd_valid, tx_queue_flush, flow_bid;
    logic        flush_seen = 1'b0, cmdv_seen = 1'b0;
    wire logic   hready;
    int          n_fail = 0, cmp_count = 0;

    assign hready = hreadyout;
    always #4 hclk = ~hclk;

    ifc_flow_ctrl ifc_flow_ctrl_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_err(rx_err),
        .rx_break(rx_break), .rx_room(rx_room), .rx_fill(rx_fill), .rx_push(rx_push),
        .rx_push_data(rx_push_data), .rx_push_err(rx_push_err), .tx_enable(tx_enable),
        .tx_flow_req(tx_flow_req), .tx_flow_char(tx_flow_char),
        .tx_flow_is_pause(tx_flow_is_pause), .tx_flow_ack(tx_flow_ack),
        .tx_cmd_valid(tx_cmd_valid), .tx_cmd(tx_cmd), .tx_queue_flush(tx_queue_flush),
        .flow_bid(flow_bid), .flow_bid_level(flow_bid_level));

    ifc_tx_model ifc_tx_model_i (.hclk(hclk), .hresetn(hresetn), .slow(slow),
        .tx_flow_req(tx_flow_req), .tx_flow_char(tx_flow_char),
        .tx_flow_is_pause(tx_flow_is_pause), .tx_flow_ack(tx_flow_ack),
        .n_pause(n_pause), .n_resume(n_resume), .last_char(last_char));

    // one-cycle pulses are latched so a check later on cannot miss them
    always @(posedge hclk) begin
        if (tx_queue_flush === 1'b1) flush_seen <= 1'b1;
        if (tx_cmd_valid === 1'b1) cmdv_seen <= 1'b1;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc

    task automatic edge_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            $display("MISMATCH t=%0t bus wait timed out", $time);
            close_out();
        end
    endtask : edge_rdy

    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        edge_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        edge_rdy();
        rd = hrdata;
    endtask : bus

    task automatic cmd(input logic [4:0] c);
        bus(1'b1, 8'h04, {c, 3'b000});
        cyc(2);
    endtask : cmd

    task automatic rx(input logic [7:0] c, input logic [2:0] e, input logic b);
        rx_char_valid <= 1'b1;
        rx_char       <= c;
        rx_err        <= e;
        rx_break      <= b;
        @(posedge hclk);
        rx_char_valid <= 1'b0;
        rx_break      <= 1'b0;
        @(posedge hclk);
        pv = rx_push;
        pd = rx_push_data;
        pe = rx_push_err;
    endtask : rx

    task automatic wait_cnt(input logic [8:0] total);
        int k;
        k = 0;
        while ((9'(n_pause) + 9'(n_resume)) !== total && k < 80) begin
            @(posedge hclk);
            k++;
        end
        if ((9'(n_pause) + 9'(n_resume)) !== total) begin
            n_fail++;
            $display("MISMATCH t=%0t flow char wait timed out", $time);
            close_out();
        end
    endtask : wait_cnt

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        cyc(2);
        chk(32'({tx_enable, hresp}), 32'h2);
        bus(1'b0, 8'h00, 8'h00); chk(rd, 32'h0);
        bus(1'b1, 8'h08, 8'h11);
        bus(1'b1, 8'h0C, 8'h13);
        bus(1'b1, 8'h10, 8'h10);
        bus(1'b1, 8'h1C, 8'h05);
        rx(8'h13, 3'h0, 1'b0); chk(32'({pv, pd}), 32'h113);
        cyc(2); chk(32'({tx_enable, flow_bid, flow_bid_level}), 32'h305);
        bus(1'b0, 8'h14, 8'h00); chk(rd, 32'h10);
        bus(1'b0, 8'h18, 8'h00); chk(rd, 32'h0E);
        cyc(2); chk(32'(flow_bid), 32'h0);
        bus(1'b1, 8'h00, 8'h04);
        rx(8'h13, 3'h5, 1'b0); chk(32'({pv, pe}), 32'hD);
        cyc(1); chk(32'(tx_enable), 32'h0);
        chk(32'(flush_seen), 32'h0);
        cmdv_seen <= 1'b0;
        cmd(5'h01); chk(32'({tx_enable, cmdv_seen}), 32'h0);
        bus(1'b0, 8'h18, 8'h00); chk(rd, 32'h4E);
        bus(1'b1, 8'h00, 8'h84);
        rx(8'h11, 3'h0, 1'b0); chk(32'(pv), 32'h0);
        cyc(1); chk(32'(tx_enable), 32'h1);
        rx(8'h41, 3'h0, 1'b0); chk(32'({pv, pd}), 32'h141);
        rx_room <= 1'b0;
        bus(1'b1, 8'h00, 8'h04);
        rx(8'h13, 3'h0, 1'b0); cyc(1); chk(32'({pv, tx_enable}), 32'h1);
        rx_room <= 1'b1;
        bus(1'b1, 8'h0C, 8'h00);
        rx(8'hA5, 3'h0, 1'b1); cyc(1); chk(32'({pv, pd, tx_enable}), 32'h200);
        flush_seen <= 1'b0;
        cmd(5'h1F); chk(32'({tx_enable, flush_seen}), 32'h3);
        rx(8'h00, 3'h0, 1'b1); cyc(2); chk(32'({tx_enable, flow_bid, pv}), 32'h5);
        bus(1'b1, 8'h0C, 8'h13);
        bus(1'b1, 8'h00, 8'h08);
        rx_fill <= 5'd12; cyc(20); chk(32'(n_pause), 32'h0);
        rx_fill <= 5'd13; wait_cnt(9'd1); chk(32'({n_pause, last_char}), 32'h113);
        chk(32'(flow_bid), 32'h0);
        bus(1'b0, 8'h18, 8'h00); chk(rd & 32'h30, 32'h30);
        rx_fill <= 5'd8; cyc(20); chk(32'(n_resume), 32'h0);
        rx_fill <= 5'd7; wait_cnt(9'd2); chk(32'({n_resume, last_char}), 32'h111);
        slow <= 1'b1;
        rx_fill <= 5'd13;
        cyc(4);
        cmd(5'h14);
        cmd(5'h12); chk(32'({tx_flow_req, tx_flow_is_pause}), 32'h3);
        rx_fill <= 5'd10; cyc(3); chk(32'(tx_flow_req), 32'h0);
        slow <= 1'b0; cyc(20); chk(32'(n_pause), 32'h1);
        rx_fill <= 5'd13;
        wait_cnt(9'd3);
        bus(1'b1, 8'h00, 8'h00);
        bus(1'b0, 8'h18, 8'h00); chk(rd & 32'h20, 32'h0);
        rx_fill <= 5'd7; cyc(20); chk(32'(n_resume), 32'h1);
        cmd(5'h15); chk(32'(tx_enable), 32'h0);
        cmd(5'h02); chk(32'({cmdv_seen, tx_cmd}), 32'h22);
        cmd(5'h01);
        rx(8'h11, 3'h0, 1'b0); cyc(2); chk(32'(tx_enable), 32'h0);
        cmd(5'h16); chk(32'(tx_enable), 32'h1);
        slow <= 1'b1;
        cmd(5'h13);
        cmd(5'h13); chk(32'({tx_flow_req, tx_flow_is_pause, tx_flow_char}), 32'h313);
        cmd(5'h12); chk(32'({tx_flow_req, tx_flow_is_pause, tx_flow_char}), 32'h211);
        cmd(5'h14); chk(32'(tx_flow_req), 32'h0);
        slow <= 1'b0; cyc(20); chk(32'({n_pause, n_resume}), 32'h201);
        cmd(5'h12); wait_cnt(9'd4); chk(32'(n_resume), 32'h2);
        close_out();
    end
endmodule : inband_flow_control_tb
